// ==== verilog/instr_decode_pkg.sv ====
// Constants shared by the instruction word decoder and its opcode table.
package instr_decode_pkg;
  localparam int IW_WIDTH      = 24;
  localparam int OPC_WIDTH     = 8;
  localparam int OPC_LSB       = 16;
  localparam int OPC_MSB       = 23;
  localparam int WORKING_REG_ZERO_SEL_W    = 4;
  localparam int FILE_ADDR_W   = 13;
  localparam int LIT_W         = 16;
  localparam int BIT_SEL_W     = 4;
  localparam int DBL_WORD_W    = 48;
  localparam int EXTRA_W       = 2;
  localparam int TBL_DEPTH     = 256;

  // Operand field positions inside the low sixteen bits.
  localparam int BASE_LSB      = 15;
  localparam int DEST_LSB      = 7;
  localparam int SRC_LSB       = 0;
  localparam int DEST_SEL_BIT  = 13;
  localparam int BITLIT_LSB    = 12;
  localparam int BIT_IND_BIT   = 11;
  localparam int SAME_DST_BIT  = 6;
  localparam int LIT_LSB       = 4;

  // Opcode classes held in the lookup table.
  localparam logic [3:0] CLS_SIMPLE  = 4'h0;
  localparam logic [3:0] CLS_REGOP   = 4'h1;
  localparam logic [3:0] CLS_FILEOP  = 4'h2;
  localparam logic [3:0] CLS_BITOP   = 4'h3;
  localparam logic [3:0] CLS_LITOP   = 4'h4;
  localparam logic [3:0] CLS_COND    = 4'h5;
  localparam logic [3:0] CLS_SKIP    = 4'h6;
  localparam logic [3:0] CLS_BRANCH  = 4'h7;
  localparam logic [3:0] CLS_INDJMP  = 4'h8;
  localparam logic [3:0] CLS_TABLE   = 4'h9;
  localparam logic [3:0] CLS_RETURN  = 4'ha;
  localparam logic [3:0] CLS_DBLMOV  = 4'hb;
  localparam logic [3:0] CLS_TWOWORD = 4'hc;

  // Opcodes with fixed meaning in this decoder.
  localparam logic [7:0] OPC_NOP      = 8'h00;
  localparam logic [7:0] OPC_JUMP     = 8'h04;
  localparam logic [7:0] OPC_CALL     = 8'h02;
  localparam logic [7:0] OPC_DO       = 8'h08;
  localparam logic [7:0] OPC_BRANCH   = 8'h37;
  localparam logic [7:0] OPC_INDJMP   = 8'h01;
  localparam logic [7:0] OPC_RETURN   = 8'h06;
  localparam logic [7:0] OPC_IRET     = 8'h07;
  localparam logic [7:0] OPC_TBLRD    = 8'hba;
  localparam logic [7:0] OPC_TBLWR    = 8'hbb;
  localparam logic [7:0] OPC_DBLMOV   = 8'hbe;
  localparam logic [7:0] OPC_SKIP_LO  = 8'he6;
  localparam logic [7:0] OPC_SKIP_HI  = 8'he7;
  localparam logic [7:0] OPC_COND_LO  = 8'h30;
  localparam logic [7:0] OPC_COND_HI  = 8'h3f;
  localparam logic [7:0] OPC_BIT_LO   = 8'ha0;
  localparam logic [7:0] OPC_BIT_HI   = 8'haf;
  localparam logic [7:0] OPC_FILE_LO  = 8'hec;
  localparam logic [7:0] OPC_FILE_HI  = 8'hef;
  localparam logic [7:0] OPC_LIT_LO   = 8'hb0;
  localparam logic [7:0] OPC_LIT_HI   = 8'hb3;

  // Extra cycle counts beyond the first.
  localparam logic [1:0] EXTRA_NONE  = 2'h0;
  localparam logic [1:0] EXTRA_ONE   = 2'h1;
  localparam logic [1:0] EXTRA_TWO   = 2'h2;
endpackage : instr_decode_pkg

// ==== verilog/opcode_class_rom.sv ====
// Registered opcode-to-class lookup table.
module opcode_class_rom
  import instr_decode_pkg::*;
#(
  parameter int DEPTH = TBL_DEPTH
) (
  // Clock and clock enable.
  input  wire logic       clk,
  input  wire logic       ce,
  // Lookup.
  input  wire logic [7:0] opcode,
  output logic      [3:0] cls_ff
);
  logic [3:0] table_q [DEPTH];

  function automatic logic [3:0] classify(input logic [7:0] o);
    logic [3:0] c;
    c = CLS_REGOP;
    if (o == OPC_JUMP || o == OPC_CALL || o == OPC_DO) c = CLS_TWOWORD;
    else if (o == OPC_BRANCH) c = CLS_BRANCH;
    else if (o == OPC_INDJMP) c = CLS_INDJMP;
    else if (o == OPC_RETURN || o == OPC_IRET) c = CLS_RETURN;
    else if (o == OPC_TBLRD || o == OPC_TBLWR) c = CLS_TABLE;
    else if (o == OPC_DBLMOV) c = CLS_DBLMOV;
    else if (o == OPC_SKIP_LO || o == OPC_SKIP_HI) c = CLS_SKIP;
    else if (o >= OPC_COND_LO && o <= OPC_COND_HI) c = CLS_COND;
    else if (o >= OPC_BIT_LO && o <= OPC_BIT_HI) c = CLS_BITOP;
    else if (o >= OPC_FILE_LO && o <= OPC_FILE_HI) c = CLS_FILEOP;
    else if (o >= OPC_LIT_LO && o <= OPC_LIT_HI) c = CLS_LITOP;
    else if (o == OPC_NOP) c = CLS_SIMPLE;
    return c;
  endfunction : classify

  // The table is fixed at elaboration so the read is a plain registered lookup.
  for (genvar i = 0; i < DEPTH; i++) begin : g_tbl
    assign table_q[i] = classify(8'(i));
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      cls_ff <= table_q[opcode];
    end
  end
endmodule : opcode_class_rom

// ==== verilog/instr_word_decode_timing.sv ====
// Instruction word decoder with operand selection and cycle timing.
module instr_word_decode_timing
  import instr_decode_pkg::*;
#(
  parameter int WORD_W = IW_WIDTH
) (
  // Clock and control.
  input  wire logic                   MCLK,
  input  wire logic                   RST,
  input  wire logic                   CE,
  // Fetch side.
  input  wire logic [WORD_W-1:0]      FETCH_WORD,
  input  wire logic                   FETCH_VALID,
  output logic                        FETCH_HOLD,
  // Execute side status.
  input  wire logic                   COND_TRUE,
  input  wire logic                   PC_CHANGED,
  input  wire logic                   SKIP_TAKEN,
  input  wire logic                   LONG_PATH,
  // Decoded instruction.
  output logic                        ISSUE_VALID,
  output logic [OPC_WIDTH-1:0]        OPCODE,
  output logic [3:0]                  INSTR_CLASS,
  output logic [DBL_WORD_W-1:0]       FULL_WORD,
  output logic                        EXEC_NOP,
  output logic [WORKING_REG_ZERO_SEL_W-1:0]       BASE_SRC_REG,
  output logic [WORKING_REG_ZERO_SEL_W-1:0]       SECOND_SRC_REG,
  output logic [WORKING_REG_ZERO_SEL_W-1:0]       DEST_REG,
  output logic [FILE_ADDR_W-1:0]      FILE_ADDR,
  output logic                        DEST_WORKING_REG_ZERO,
  output logic [BIT_SEL_W-1:0]        BIT_SEL,
  output logic                        BIT_FROM_BASE,
  output logic [LIT_W-1:0]            LITERAL,
  output logic                        DEST_IS_BASE,
  output logic [1:0]                  CYCLE_COUNT
);
  typedef enum logic [3:0] {
    ST_DECODE = 4'h1,
    ST_SECOND = 4'h2,
    ST_CLASS  = 4'h4,
    ST_STALL  = 4'h8
  } state_e;

  state_e             state_ff;
  logic [1:0]         stall_ff;
  logic [WORD_W-1:0]  word_ff;
  logic [WORD_W-1:0]  second_ff;
  logic               skip_next_ff;
  logic [3:0]         cls;
  logic [7:0]         opc;
  logic               two_word;
  logic [1:0]         nxt_extra;
  logic [1:0]         nxt_stall;

  assign opc = FETCH_WORD[OPC_MSB:OPC_LSB];

  // A skipped word reports the skip penalty and holds fetch for exactly that.
  assign nxt_stall = skip_next_ff ? EXTRA_ONE : nxt_extra;

  opcode_class_rom #(
    .DEPTH (TBL_DEPTH)
  ) u_rom (
    .clk    (MCLK),
    .ce     (CE),
    // The lookup starts on the take edge, so the class is ready to classify.
    .opcode (opc),
    .cls_ff (cls)
  );

  assign two_word = (cls == CLS_TWOWORD);

  // The skip penalty depends on the word after the skip, known one word late.
  always_comb begin
    nxt_extra = EXTRA_NONE;
    unique case (cls)
      CLS_COND: nxt_extra = (COND_TRUE || PC_CHANGED) ? EXTRA_ONE
                                                     : EXTRA_NONE;
      CLS_BRANCH, CLS_INDJMP, CLS_TABLE, CLS_RETURN:
        nxt_extra = LONG_PATH ? EXTRA_TWO : EXTRA_ONE;
      CLS_DBLMOV: nxt_extra = EXTRA_ONE;
      CLS_TWOWORD: nxt_extra = EXTRA_NONE;
      CLS_SKIP: nxt_extra = EXTRA_NONE;
      default: nxt_extra = PC_CHANGED ? EXTRA_ONE : EXTRA_NONE;
    endcase
  end

  // Sequencer: capture, classify, gather second word, then stall.
  always_ff @(posedge MCLK) begin
    if (RST) begin
      state_ff     <= ST_DECODE;
      stall_ff     <= 2'h0;
      word_ff      <= '0;
      second_ff    <= '0;
      skip_next_ff <= 1'b0;
      FETCH_HOLD   <= 1'b0;
      ISSUE_VALID  <= 1'b0;
      CYCLE_COUNT  <= 2'h0;
      EXEC_NOP     <= 1'b0;
    end else if (CE) begin
      ISSUE_VALID <= 1'b0;
      unique case (state_ff)
        ST_DECODE: begin
          if (FETCH_VALID) begin
            word_ff    <= FETCH_WORD;
            FETCH_HOLD <= 1'b1;
            state_ff   <= ST_CLASS;
          end
        end
        ST_CLASS: begin
          if (two_word) begin
            FETCH_HOLD <= 1'b0;
            state_ff   <= ST_SECOND;
          end else begin
            // Second word alone: upper byte zero decodes as no-operation.
            EXEC_NOP    <= skip_next_ff ||
                           (word_ff[OPC_MSB:OPC_LSB] == OPC_NOP);
            ISSUE_VALID <= 1'b1;
            skip_next_ff <= (cls == CLS_SKIP) && SKIP_TAKEN;
            CYCLE_COUNT <= nxt_stall;
            stall_ff    <= nxt_stall;
            FETCH_HOLD  <= (nxt_stall != EXTRA_NONE);
            state_ff    <= (nxt_stall != EXTRA_NONE) ? ST_STALL : ST_DECODE;
          end
        end
        ST_SECOND: begin
          if (FETCH_VALID) begin
            second_ff   <= FETCH_WORD;
            ISSUE_VALID <= 1'b1;
            EXEC_NOP    <= skip_next_ff;
            skip_next_ff <= 1'b0;
            CYCLE_COUNT <= skip_next_ff ? EXTRA_TWO : EXTRA_ONE;
            stall_ff    <= skip_next_ff ? EXTRA_TWO : EXTRA_ONE;
            FETCH_HOLD  <= 1'b1;
            state_ff    <= ST_STALL;
          end
        end
        ST_STALL: begin
          if (stall_ff == EXTRA_ONE) begin
            FETCH_HOLD <= 1'b0;
            state_ff   <= ST_DECODE;
          end
          stall_ff <= stall_ff - 2'h1;
        end
        default: state_ff <= ST_DECODE;
      endcase
    end
  end

  // Operand fields registered with the instruction word.
  always_ff @(posedge MCLK) begin
    if (RST) begin
      OPCODE                <= '0;
      INSTR_CLASS           <= CLS_SIMPLE;
      FULL_WORD             <= '0;
      BASE_SRC_REG          <= '0;
      SECOND_SRC_REG        <= '0;
      DEST_REG              <= '0;
      FILE_ADDR             <= '0;
      DEST_WORKING_REG_ZERO <= 1'b0;
      BIT_SEL               <= '0;
      BIT_FROM_BASE         <= 1'b0;
      LITERAL               <= '0;
      DEST_IS_BASE          <= 1'b0;
    end else if (CE && state_ff == ST_CLASS) begin
      OPCODE         <= word_ff[OPC_MSB:OPC_LSB];
      INSTR_CLASS    <= cls;
      FULL_WORD      <= {word_ff, {WORD_W{1'b0}}};
      BASE_SRC_REG   <= word_ff[BASE_LSB -: WORKING_REG_ZERO_SEL_W];
      SECOND_SRC_REG <= word_ff[SRC_LSB +: WORKING_REG_ZERO_SEL_W];
      DEST_REG       <= word_ff[DEST_LSB +: WORKING_REG_ZERO_SEL_W];
      FILE_ADDR      <= word_ff[FILE_ADDR_W-1:0];
      DEST_WORKING_REG_ZERO <= (cls == CLS_FILEOP) &&
                               word_ff[DEST_SEL_BIT];
      BIT_FROM_BASE  <= word_ff[BIT_IND_BIT];
      BIT_SEL        <= word_ff[BITLIT_LSB +: BIT_SEL_W];
      LITERAL        <= (cls == CLS_LITOP) ?
                        {4'h0, word_ff[LIT_LSB +: 12]} :
                        word_ff[LIT_W-1:0];
      DEST_IS_BASE   <= (cls == CLS_LITOP) &&
                        word_ff[SAME_DST_BIT];
    end else if (CE && state_ff == ST_SECOND && FETCH_VALID) begin
      FULL_WORD <= {word_ff, FETCH_WORD};
    end
  end
endmodule : instr_word_decode_timing

// ==== test/prog_mem_model.sv ====
// Program memory model feeding words to the decoder's fetch side.
module prog_mem_model
  import instr_decode_pkg::*;
(
  // Clock and control.
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                ce,
  // Fetch side.
  input  wire logic                hold,
  output logic [IW_WIDTH-1:0]      word,
  output logic                     valid
);
  logic [IW_WIDTH-1:0] mem [16];
  logic [IW_WIDTH-1:0] last_ff = '0;
  logic [3:0]          rd_ff = '0;
  logic [3:0]          wr = '0;
  function automatic void push(input logic [IW_WIDTH-1:0] w);
    mem[wr] = w;
    wr = wr + 4'h1;
  endfunction : push
  // An idle bus shows the inverse of the last word, so stale data never
  // passes for a fresh fetch.
  assign valid = rd_ff != wr;
  assign word  = valid ? mem[rd_ff] : ~last_ff;
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_ff <= wr;
    end else if (ce && valid && !hold) begin
      last_ff <= mem[rd_ff];
      rd_ff   <= rd_ff + 4'h1;
    end
  end
endmodule : prog_mem_model

// ==== test/instr_decode_checker_assertions.sv ====
// Timing and decode checks on the decoder's top-level ports.
module instr_decode_checker
  import instr_decode_pkg::*;
#(
  parameter int WORD_W = IW_WIDTH
) (
  // Clock and control.
  input wire logic              MCLK,
  input wire logic              RST,
  input wire logic              CE,
  // Fetch side.
  input wire logic [WORD_W-1:0] FETCH_WORD,
  input wire logic              FETCH_VALID,
  input wire logic              FETCH_HOLD,
  // Decoded outputs.
  input wire logic              ISSUE_VALID,
  input wire logic [7:0]        OPCODE,
  input wire logic [3:0]        INSTR_CLASS,
  input wire logic              EXEC_NOP,
  input wire logic [1:0]        CYCLE_COUNT
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  wire single = ISSUE_VALID && INSTR_CLASS != CLS_TWOWORD;
  a_take_holds: assert property (CE && FETCH_VALID && !FETCH_HOLD |=> FETCH_HOLD) else $error("hold missing after take");
  a_issue_pulse: assert property (ISSUE_VALID && CE |=> !ISSUE_VALID) else $error("issue longer than one cycle");
  a_opcode_field: assert property (single && !EXEC_NOP |-> OPCODE == $past(FETCH_WORD[OPC_MSB:OPC_LSB], 2)) else $error("opcode not top byte");
  a_second_nop: assert property (ISSUE_VALID && OPCODE == OPC_NOP |-> EXEC_NOP) else $error("zero top byte not a no-operation");
  a_dblmov_two: assert property (ISSUE_VALID && OPCODE == OPC_DBLMOV |-> CYCLE_COUNT == EXTRA_ONE) else $error("double move count");
  a_twoword_two: assert property (ISSUE_VALID && INSTR_CLASS == CLS_TWOWORD && !EXEC_NOP |-> CYCLE_COUNT == EXTRA_ONE) else $error("two-word count");
  a_skip_pair: assert property (ISSUE_VALID && INSTR_CLASS == CLS_TWOWORD
    && EXEC_NOP |-> CYCLE_COUNT == EXTRA_TWO) else $error("skip pair count");
  a_no_extra: assert property (single && CYCLE_COUNT == EXTRA_NONE |-> !FETCH_HOLD) else $error("stall without extra");
  a_extra_one: assert property (single && CYCLE_COUNT == EXTRA_ONE |-> FETCH_HOLD ##1 !FETCH_HOLD) else $error("one-cycle stall");
  a_extra_two: assert property (single && CYCLE_COUNT == EXTRA_TWO |-> FETCH_HOLD [*2] ##1 !FETCH_HOLD) else $error("two-cycle stall");
  a_reset_clear: assert property (disable iff (1'b0) RST |=> !ISSUE_VALID && !FETCH_HOLD) else $error("outputs not cleared by reset");
  c_two_extra: cover property (ISSUE_VALID && CYCLE_COUNT == EXTRA_TWO);
  c_two_word: cover property (ISSUE_VALID && INSTR_CLASS == CLS_TWOWORD);
  c_nop: cover property (ISSUE_VALID && EXEC_NOP);
endmodule : instr_decode_checker
bind instr_word_decode_timing instr_decode_checker #(.WORD_W(WORD_W)) i_chk (
  .MCLK(MCLK), .RST(RST), .CE(CE), .FETCH_WORD(FETCH_WORD),
  .FETCH_VALID(FETCH_VALID), .FETCH_HOLD(FETCH_HOLD),
  .ISSUE_VALID(ISSUE_VALID), .OPCODE(OPCODE), .INSTR_CLASS(INSTR_CLASS),
  .EXEC_NOP(EXEC_NOP), .CYCLE_COUNT(CYCLE_COUNT));

// ==== test/instr_word_decode_timing_test.sv ====
// Self-checking bench for the instruction word decoder.
module instr_word_decode_timing_test
  import instr_decode_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, rst, ce, cond, pcc, skip, lng, hold, valid, issue, no_operation;
  logic [IW_WIDTH-1:0]    word;
  logic [DBL_WORD_W-1:0]  full;
  logic [FILE_ADDR_W-1:0] faddr;
  logic [1:0]             cnt;
  logic [3:0]             base, src2, dst, bsel, cls;
  logic [7:0]             opc;
  logic [15:0]            lit;
  logic                   wz, bbase, dib;
  int mismatches = 0;
  int n_compared = 0;
  instr_word_decode_timing i_dut (
    .MCLK(mclk), .RST(rst), .CE(ce), .FETCH_WORD(word),
    .FETCH_VALID(valid), .FETCH_HOLD(hold), .COND_TRUE(cond),
    .PC_CHANGED(pcc), .SKIP_TAKEN(skip), .LONG_PATH(lng),
    .ISSUE_VALID(issue), .OPCODE(opc), .INSTR_CLASS(cls), .FULL_WORD(full),
    .EXEC_NOP(no_operation), .BASE_SRC_REG(base), .SECOND_SRC_REG(src2),
    .DEST_REG(dst), .FILE_ADDR(faddr), .DEST_WORKING_REG_ZERO(wz),
    .BIT_SEL(bsel), .BIT_FROM_BASE(bbase), .LITERAL(lit),
    .DEST_IS_BASE(dib), .CYCLE_COUNT(cnt));
  prog_mem_model i_mem (.mclk(mclk), .rst(rst), .ce(ce), .hold(hold),
    .word(word), .valid(valid));
  task automatic test_done();
    if (mismatches == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  task automatic check(input string what, input logic [47:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check
  task automatic wait_issue();
    for (int n = 0; n < 20 && issue !== 1'b1; n++) @(negedge mclk);
    check("issue", 48'h1, 48'(issue));
  endtask : wait_issue
  // Counts the stall from the issue cycle, so the extra cycles are seen
  // at the fetch side and not only in the reported count.
  task automatic issue_wait(input logic [1:0] extra);
    int n;
    wait_issue();
    check("extra", 48'(extra), 48'(cnt));
    for (n = 0; n < 5 && hold === 1'b1; n++) @(negedge mclk);
    check("stall", 48'(extra), 48'(n));
    @(negedge mclk);
  endtask : issue_wait
  task automatic run(input logic [23:0] w, input logic [1:0] extra);
    i_mem.push(w);
    issue_wait(extra);
  endtask : run
  task automatic t_file();
    ce = 0;
    i_mem.push({OPC_FILE_LO, 16'h1abc});
    repeat (3) @(negedge mclk);
    check("frozen", 48'h0, 48'(issue));
    ce = 1;
    issue_wait(EXTRA_NONE);
    check("faddr", 48'h1abc, 48'(faddr));
    check("wreg0", 48'h0, 48'(wz));
  endtask : t_file
  task automatic t_ops();
    run({8'h40, 16'ha3c5}, EXTRA_NONE);
    check("opcode", 48'h40, 48'(opc));
    check("class", 48'(CLS_REGOP), 48'(cls));
    check("base", 48'ha, 48'(base));
    check("src", 48'h5, 48'(src2));
    check("dest", 48'h7, 48'(dst));
    run({OPC_FILE_HI, 16'h2005}, EXTRA_NONE);
    check("faddr", 48'h0005, 48'(faddr));
    check("wreg0", 48'h1, 48'(wz));
    run({OPC_BIT_LO, 16'h9800}, EXTRA_NONE);
    check("bitsel", 48'h9, 48'(bsel));
    check("bitbase", 48'h1, 48'(bbase));
    run({OPC_LIT_LO, 16'h3c47}, EXTRA_NONE);
    check("literal", 48'h03c4, 48'(lit));
    check("samedst", 48'h1, 48'(dib));
    check("litbase", 48'h3, 48'(base));
  endtask : t_ops
  task automatic t_cond();
    for (int k = 0; k < 2; k++) begin
      cond = k[0];
      run({OPC_COND_LO, 16'h0010}, k ? EXTRA_ONE : EXTRA_NONE);
    end
    cond = 0;
    pcc = 1;
    run({OPC_FILE_HI, 16'h0003}, EXTRA_ONE);
    pcc = 0;
  endtask : t_cond
  task automatic t_group();
    logic [7:0] ops [6] = '{OPC_BRANCH, OPC_INDJMP, OPC_RETURN, OPC_IRET,
                            OPC_TBLRD, OPC_TBLWR};
    foreach (ops[i]) begin
      for (int k = 0; k < 2; k++) begin
        lng = k[0];
        run({ops[i], 16'h0000}, k ? EXTRA_TWO : EXTRA_ONE);
      end
    end
    lng = 0;
  endtask : t_group
  task automatic t_two();
    logic [7:0]  ops [3] = '{OPC_JUMP, OPC_CALL, OPC_DO};
    logic [23:0] lo;
    foreach (ops[i]) begin
      lo = {8'h00, 16'h5a00 + 16'(i)};
      i_mem.push({ops[i], 16'h0100});
      i_mem.push(lo);
      wait_issue();
      check("full", {ops[i], 16'h0100, lo}, full);
      check("extra", 48'(EXTRA_ONE), 48'(cnt));
      for (int n = 0; n < 5 && hold === 1'b1; n++) @(negedge mclk);
      @(negedge mclk);
    end
    run({OPC_DBLMOV, 16'h0000}, EXTRA_ONE);
    run(24'h001234, EXTRA_NONE);
    check("nop", 48'h1, 48'(no_operation));
  endtask : t_two
  task automatic t_skip();
    for (int k = 0; k < 2; k++) begin
      skip = 1;
      lng = k[0];
      i_mem.push({OPC_SKIP_LO, 16'h0000});
      i_mem.push(k ? {OPC_JUMP, 16'h0040} : {OPC_FILE_LO, 16'h0000});
      if (k) i_mem.push(24'h000000);
      issue_wait(EXTRA_NONE);
      issue_wait(k ? EXTRA_TWO : EXTRA_ONE);
      check("skipnop", 48'h1, 48'(no_operation));
      // Reset mid-run flushes whatever the skip left in the pipe.
      rst = 1;
      skip = 0;
      repeat (2) @(negedge mclk);
      rst = 0;
    end
    lng = 0;
  endtask : t_skip
  initial begin
    mclk = 0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    test_done();
  end
  initial begin
    {rst, ce, cond, pcc, skip, lng} = 6'b110000;
    repeat (5) @(negedge mclk);
    rst = 0;
    t_file();
    t_ops();
    t_cond();
    t_group();
    t_two();
    t_skip();
    test_done();
  end
endmodule : instr_word_decode_timing_test
